/* verilog/complementary_dead_band_delay.sv */
// dead-band delay stage of the complementary output generator
`timescale 1ns/1ns
module complementary_dead_band_delay #(
	parameter int CHAIN_LEN = dead_band_pkg::CHAIN_LEN_DEFAULT
) (
	input  wire logic                                ref_clk,
	input  wire logic                                nrst,
	input  wire logic                                event_in,
	input  wire logic [dead_band_pkg::ADDR_WIDTH-1:0] addr,
	input  wire logic [dead_band_pkg::DATA_WIDTH-1:0] wdata,
	input  wire logic                                wr,
	input  wire logic                                rd,
	output logic      [dead_band_pkg::DATA_WIDTH-1:0] rdata,
	output logic                                     primary_out,
	output logic                                     complementary_out
);
	import dead_band_pkg::*;

	// elaboration checks
	if (CHAIN_LEN < 1 || CHAIN_LEN > 255) begin : g_bad_chain
		$error("chain length out of range");
	end

	if (COUNT_WIDTH + 2 != DATA_WIDTH) begin : g_bad_width
		$error("count field must leave two unused upper bits");
	end

	if (RISING_SEL_BIT >= DATA_WIDTH || FALLING_SEL_BIT >= DATA_WIDTH) begin : g_bad_sel
		$error("source select bit outside the control register");
	end

	logic                   sync1_reg;
	logic                   sync1_next;
	logic                   sync2_reg;
	logic                   sync2_next;
	logic                   prev_reg;
	logic                   prev_next;
	logic [COUNT_WIDTH-1:0] rising_dead_count_reg;
	logic [COUNT_WIDTH-1:0] rising_dead_count_next;
	logic [COUNT_WIDTH-1:0] falling_dead_count_reg;
	logic [COUNT_WIDTH-1:0] falling_dead_count_next;
	logic [DATA_WIDTH-1:0]  source_ctrl_reg;
	logic [DATA_WIDTH-1:0]  source_ctrl_next;
	logic [DATA_WIDTH-1:0]  rdata_next;
	logic                   primary_next;
	logic                   complementary_next;
	logic                   rise;
	logic                   fall;
	logic                   rise_done;
	logic                   fall_done;

	// keep the implemented low bits of a count write
	function automatic logic [COUNT_WIDTH-1:0] count_field(
		input logic [DATA_WIDTH-1:0] value
	);
		count_field = value[COUNT_WIDTH-1:0];
	endfunction : count_field

	// unimplemented upper bits of a count read back as zero
	function automatic logic [DATA_WIDTH-1:0] count_readback(
		input logic [COUNT_WIDTH-1:0] value
	);
		count_readback = {{(DATA_WIDTH - COUNT_WIDTH){1'b0}}, value};
	endfunction : count_readback

	// edge detect on the synchronised event
	assign rise = sync2_reg & ~prev_reg;
	assign fall = ~sync2_reg & prev_reg;

	// dead-band count registers
	always_comb begin
		rising_dead_count_next  = rising_dead_count_reg;
		falling_dead_count_next = falling_dead_count_reg;
		if (wr) begin
			case (addr)
				RISING_COUNT_ADDR: begin
					rising_dead_count_next = count_field(wdata);
				end
				FALLING_COUNT_ADDR: begin
					falling_dead_count_next = count_field(wdata);
				end
				default: begin
					rising_dead_count_next = rising_dead_count_reg;
				end
			endcase
		end
	end

	// counts held outside reset; power-on leaves them unknown
	always_ff @(posedge ref_clk) begin
		rising_dead_count_reg  <= rising_dead_count_next;
		falling_dead_count_reg <= falling_dead_count_next;
	end

	// source select control; the polarity bits are stored but drive nothing
	always_comb begin
		source_ctrl_next = source_ctrl_reg;
		if (wr) begin
			case (addr)
				SOURCE_CTRL_ADDR: begin
					source_ctrl_next = wdata;
				end
				default: begin
					source_ctrl_next = source_ctrl_reg;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			source_ctrl_reg <= SOURCE_CTRL_RESET;
		end else begin
			source_ctrl_reg <= source_ctrl_next;
		end
	end

	// read data, one cycle after the strobe, zero otherwise
	always_comb begin
		rdata_next = '0;
		if (rd) begin
			case (addr)
				RISING_COUNT_ADDR:  rdata_next = count_readback(rising_dead_count_reg);
				FALLING_COUNT_ADDR: rdata_next = count_readback(falling_dead_count_reg);
				SOURCE_CTRL_ADDR:   rdata_next = source_ctrl_reg;
				default:            rdata_next = '0;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			rdata <= '0;
		end else begin
			rdata <= rdata_next;
		end
	end

	// two-flop synchroniser and edge history
	always_comb begin
		sync1_next = event_in;
		sync2_next = sync1_reg;
		prev_next  = sync2_reg;
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			prev_reg  <= 1'b0;
		end else begin
			sync1_reg <= sync1_next;
			sync2_reg <= sync2_next;
			prev_reg  <= prev_next;
		end
	end

	// outputs: delayed set, opposite edge clears
	always_comb begin
		primary_next       = primary_out;
		complementary_next = complementary_out;
		if (rise_done) begin
			primary_next = 1'b1;
		end
		if (fall_done) begin
			complementary_next = 1'b1;
		end
		// clear comes last so a late done can never overlap the other output
		if (rise) begin
			complementary_next = 1'b0;
		end
		if (fall) begin
			primary_next = 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			primary_out       <= 1'b0;
			complementary_out <= 1'b0;
		end else begin
			primary_out       <= primary_next;
			complementary_out <= complementary_next;
		end
	end

	edge_delay_timer #(
		.COUNT_WIDTH (COUNT_WIDTH),
		.CHAIN_LEN   (CHAIN_LEN)
	) u_rising (
		.ref_clk   (ref_clk),
		.nrst      (nrst),
		.start     (rise),
		.level_in  (sync2_reg),
		.use_chain (source_ctrl_reg[RISING_SEL_BIT]),
		.count     (rising_dead_count_reg),
		.done      (rise_done)
	);

	edge_delay_timer #(
		.COUNT_WIDTH (COUNT_WIDTH),
		.CHAIN_LEN   (CHAIN_LEN)
	) u_falling (
		.ref_clk   (ref_clk),
		.nrst      (nrst),
		.start     (fall),
		.level_in  (~sync2_reg),
		.use_chain (source_ctrl_reg[FALLING_SEL_BIT]),
		.count     (falling_dead_count_reg),
		.done      (fall_done)
	);
endmodule : complementary_dead_band_delay

/* verilog/dead_band_pkg.sv */
// constants for the dead-band delay stage
package dead_band_pkg;
	localparam int          COUNT_WIDTH        = 6;
	localparam int          ADDR_WIDTH         = 2;
	localparam int          DATA_WIDTH         = 8;
	localparam int          CHAIN_LEN_DEFAULT  = 4;
	localparam logic [1:0]  RISING_COUNT_ADDR  = 2'h0;
	localparam logic [1:0]  FALLING_COUNT_ADDR = 2'h1;
	localparam logic [1:0]  SOURCE_CTRL_ADDR   = 2'h2;
	localparam int          RISING_SEL_BIT     = 7;
	localparam int          FALLING_SEL_BIT    = 6;
	localparam int          POLARITY_LSB       = 0;
	localparam int          POLARITY_WIDTH     = 4;
	localparam logic [7:0]  SOURCE_CTRL_RESET  = 8'h00;
	localparam logic [5:0]  COUNT_ZERO         = 6'h00;
endpackage : dead_band_pkg

/* verilog/edge_delay_timer.sv */
// one edge delay timer: counts clock periods or chain element periods
`timescale 1ns/1ns
module edge_delay_timer #(
	parameter int COUNT_WIDTH = 6,
	parameter int CHAIN_LEN   = 4
) (
	input  wire logic                   ref_clk,
	input  wire logic                   nrst,
	input  wire logic                   start,
	input  wire logic                   level_in,
	input  wire logic                   use_chain,
	input  wire logic [COUNT_WIDTH-1:0] count,
	output logic                        done
);
	localparam int PW = COUNT_WIDTH + 8;
	if (CHAIN_LEN < 1 || CHAIN_LEN > 255) begin : g_bad_chain
		$error("chain length out of range");
	end
	if (COUNT_WIDTH < 1) begin : g_bad_count
		$error("count width must be at least one bit");
	end
	logic [PW-1:0] left_reg;
	logic [PW-1:0] left_next;
	logic          busy_reg;
	logic          busy_next;
	logic          done_next;
	logic [PW-1:0] load;

	always_comb begin
		// chain element modelled as a fixed number of clock periods
		if (use_chain) begin
			load = PW'(count) * PW'(CHAIN_LEN);
		end else begin
			load = PW'(count);
		end
		left_next = left_reg;
		busy_next = busy_reg;
		done_next = 1'b0;
		if (start) begin
			if (count == '0) begin
				busy_next = 1'b0;
				done_next = level_in;
			end else begin
				busy_next = 1'b1;
				left_next = load - PW'(1);
			end
		end else if (busy_reg) begin
			if (left_reg == '0) begin
				busy_next = 1'b0;
				done_next = level_in;
			end else begin
				left_next = left_reg - PW'(1);
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			left_reg <= '0;
			busy_reg <= 1'b0;
			done     <= 1'b0;
		end else begin
			left_reg <= left_next;
			busy_reg <= busy_next;
			done     <= done_next;
		end
	end
endmodule : edge_delay_timer

/* bench/dead_band_chk_sva.sv */
// dead-band checker
`timescale 1ns/1ns
module dead_band_chk (
	input logic       ref_clk,
	input logic       nrst,
	input logic       event_in,
	input logic [1:0] addr,
	input logic       rd,
	input logic [7:0] rdata,
	input logic       primary_out,
	input logic       complementary_out
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);
	property p_top; rd && addr < 2'h2 |=> rdata[7:6] == 2'h0; endproperty
	a_top: assert property (p_top) else $error("top bits");
	property p_idle; !rd |=> rdata == 8'h00; endproperty
	a_idle: assert property (p_idle) else $error("stale rdata");
	property p_rst; disable iff (0) !nrst |=> !(primary_out || complementary_out); endproperty
	a_rst: assert property (p_rst) else $error("out in reset");
	property p_both; !(primary_out && complementary_out); endproperty
	a_both: assert property (p_both) else $error("overlap");
	property p_pri; $rose(primary_out) |-> event_in && $past(event_in, 2); endproperty
	a_pri: assert property (p_pri) else $error("early primary");
	property p_cmp; $rose(complementary_out) |-> !(event_in || $past(event_in, 2)); endproperty
	a_cmp: assert property (p_cmp) else $error("early comp");
	cover property ($rose(primary_out));
	cover property ($rose(complementary_out));
	cover property (rd && addr == 2'h3);
endmodule : dead_band_chk
bind complementary_dead_band_delay dead_band_chk chk (.*);

/* bench/test_complementary_dead_band_delay.sv */
// dead-band bench
`timescale 1ns/1ns
module test_complementary_dead_band_delay;
	import dead_band_pkg::*;
	logic ref_clk = 1'b0, nrst = 1'b0, event_in = 1'b0, wr = 1'b0, rd = 1'b0;
	logic [1:0] addr = 2'h0;
	logic [7:0] wdata = 8'h00, rdata;
	logic primary_out, complementary_out;
	int err_count = 0, comparisons = 0, k;
	complementary_dead_band_delay uut (.*);
	initial forever #20 ref_clk = ~ref_clk;
	task give_verdict;
		$display("%0d bad of %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : give_verdict
	task chk(input string n, input logic [7:0] e, s);
		comparisons++;
		if (s !== e) begin
			err_count++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask : chk
	task bus(input logic w, input logic [1:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		{wr, rd} <= {w, !w};
		@(posedge ref_clk);
		{wr, rd} <= 2'h0;
		if (!w) #1 chk("rdata", d, rdata);
	endtask : bus
	task s_regs;
		bus(1'b1, RISING_COUNT_ADDR, 8'hFF);
		bus(1'b1, FALLING_COUNT_ADDR, 8'hEA);
		bus(1'b0, RISING_COUNT_ADDR, 8'h3F);
		bus(1'b0, FALLING_COUNT_ADDR, 8'h2A);
		bus(1'b0, 2'h3, 8'h00);
		@(posedge ref_clk);
		nrst <= 1'b0;
		@(posedge ref_clk);
		nrst <= 1'b1;
		bus(1'b0, FALLING_COUNT_ADDR, 8'h2A);
	endtask : s_regs
	task s_delay(input logic up, ch, input logic [7:0] n, input int e);
		bus(1'b1, up ? RISING_COUNT_ADDR : FALLING_COUNT_ADDR, n);
		bus(1'b1, SOURCE_CTRL_ADDR, {ch, ch, 6'h00});
		event_in <= !up;
		repeat (300) @(posedge ref_clk);
		event_in <= up;
		for (k = 0; k < 400 && (up ? primary_out : complementary_out) !== 1'b1; k++)
			@(posedge ref_clk) #1;
		chk("delay", e[7:0], k[7:0]);
	endtask : s_delay
	task s_revert;
		bus(1'b1, RISING_COUNT_ADDR, 8'h3F);
		bus(1'b1, SOURCE_CTRL_ADDR, 8'h00);
		event_in <= 1'b0;
		repeat (300) @(posedge ref_clk);
		event_in <= 1'b1;
		repeat (10) @(posedge ref_clk);
		event_in <= 1'b0;
		repeat (80) @(posedge ref_clk);
		#1 chk("revert", 8'h01, {6'h00, primary_out, complementary_out});
	endtask : s_revert
	initial begin
		repeat (12) @(posedge ref_clk);
		nrst <= 1'b1;
		s_regs();
		s_delay(1'b1, 1'b0, 8'h3F, 67);
		s_delay(1'b1, 1'b1, 8'h05, 5 * CHAIN_LEN_DEFAULT + 4);
		s_delay(1'b0, 1'b0, 8'h3F, 67);
		s_delay(1'b0, 1'b1, 8'h07, 7 * CHAIN_LEN_DEFAULT + 4);
		s_delay(1'b1, 1'b1, 8'h00, 4);
		s_revert();
		give_verdict();
	end
	initial begin
		#800000 err_count++;
		give_verdict();
	end
endmodule : test_complementary_dead_band_delay
